/* inc/sdi_pkg.sv */
`default_nettype none
package sdi_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIN = 8'h04;
  localparam logic [7:0] OFS_FUNC = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_GEAR0 = 8'h20;
  localparam logic [7:0] OFS_GEAR3 = 8'h2c;
  localparam int CTRL_TLIM_BIT = 0;
  localparam int GEAR_W = 16;
  localparam int N_GEAR = 4;
  localparam int N_EV = 4;
  localparam int EV_ESTOP = 0;
  localparam int EV_FWD_LIM = 1;
  localparam int EV_REV_LIM = 2;
  localparam int EV_MODE = 3;
  localparam logic [GEAR_W-1:0] GEAR_RST = 16'h0001;
  localparam logic [N_EV-1:0] IRQ_EN_RST = 4'h0;

  typedef struct packed {
    logic fault_alarm;
    logic fwd_inhibit;
    logic rev_inhibit;
    logic fwd_tlim;
    logic rev_tlim;
    logic jog_fwd;
    logic jog_rev;
    logic pos_mode;
    logic [1:0] gear_sel;
  } sdi_func_t;

  typedef struct packed {
    logic tlim_en;
    logic [N_EV-1:0] irq_en;
    logic [N_GEAR-1:0][GEAR_W-1:0] gear;
    logic prev_estop;
    logic prev_fwd;
    logic prev_rev;
    logic prev_mode;
    sdi_func_t func;
    logic [GEAR_W-1:0] gear_out;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } sdi_state_t;
endpackage : sdi_pkg
`default_nettype wire

/* verilog/sdi_sticky.sv */
`default_nettype none
module sdi_sticky #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Set and clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flags
  output logic [W-1:0] q
);
  logic [W-1:0] next_q;

  // Set wins over a clear in the same cycle
  always_comb begin
    next_q = (q & ~clr) | set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule : sdi_sticky
`default_nettype wire

/* verilog/sdi_top.sv */
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module sdi_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Digital inputs
  input wire logic emergency_stop_in,
  input wire logic forward_travel_limit_in,
  input wire logic reverse_travel_limit_in,
  input wire logic forward_torque_limit_sel,
  input wire logic reverse_torque_limit_sel,
  input wire logic jog_forward_in,
  input wire logic jog_reverse_in,
  input wire logic gear_numerator_sel_bit0,
  input wire logic gear_numerator_sel_bit1,
  input wire logic torque_position_switch_in,
  // Decoded functions
  output logic fault_alarm_out,
  output logic fwd_motion_inhibit,
  output logic rev_motion_inhibit,
  output logic fwd_torque_limit_on,
  output logic rev_torque_limit_on,
  output logic jog_fwd_drive,
  output logic jog_rev_drive,
  output logic position_mode,
  output logic [1:0] gear_sel,
  output logic [sdi_pkg::GEAR_W-1:0] gear_numerator,
  // Interrupt
  output logic irq
);
  sdi_pkg::sdi_state_t st;
  sdi_pkg::sdi_state_t next_st;
  logic [sdi_pkg::N_EV-1:0] ev_set;
  logic [sdi_pkg::N_EV-1:0] ev_clr;
  logic [sdi_pkg::N_EV-1:0] irq_stat;
  logic [9:0] din;
  logic acc;
  logic [7:0] ra;

  assign din = {torque_position_switch_in, gear_numerator_sel_bit1,
                gear_numerator_sel_bit0, jog_reverse_in, jog_forward_in,
                reverse_torque_limit_sel, forward_torque_limit_sel,
                reverse_travel_limit_in, forward_travel_limit_in,
                emergency_stop_in};
  assign acc = hsel && htrans[1] && hready;
  assign ra = haddr[7:0];

  sdi_sticky #(
    .W(sdi_pkg::N_EV)
  ) u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(ev_set),
    .clr(ev_clr),
    .q(irq_stat)
  );

  always_comb begin
    next_st = st;
    ev_clr = '0;
    // Opening edges of the closed-loop contacts, and any change of the torque/position switch
    ev_set = '0;
    ev_set[sdi_pkg::EV_ESTOP] = st.prev_estop && !emergency_stop_in;
    ev_set[sdi_pkg::EV_FWD_LIM] = st.prev_fwd && !forward_travel_limit_in;
    ev_set[sdi_pkg::EV_REV_LIM] = st.prev_rev && !reverse_travel_limit_in;
    ev_set[sdi_pkg::EV_MODE] = st.prev_mode != torque_position_switch_in;
    next_st.prev_estop = emergency_stop_in;
    next_st.prev_fwd = forward_travel_limit_in;
    next_st.prev_rev = reverse_travel_limit_in;
    next_st.prev_mode = torque_position_switch_in;

    // Data phase of a write
    if (st.wr_pend) begin
      if (st.wr_addr == sdi_pkg::OFS_CTRL) begin
        next_st.tlim_en = hwdata[sdi_pkg::CTRL_TLIM_BIT];
      end else if (st.wr_addr == sdi_pkg::OFS_IRQ_CLR) begin
        ev_clr = hwdata[sdi_pkg::N_EV-1:0];
      end else if (st.wr_addr == sdi_pkg::OFS_IRQ_EN) begin
        next_st.irq_en = hwdata[sdi_pkg::N_EV-1:0];
      end else if (st.wr_addr >= sdi_pkg::OFS_GEAR0 && st.wr_addr <= sdi_pkg::OFS_GEAR3
                   && st.wr_addr[1:0] == 2'h0) begin
        next_st.gear[st.wr_addr[3:2]] = hwdata[sdi_pkg::GEAR_W-1:0];
      end
    end

    // Alarm while any closed-loop contact is open
    next_st.func.fault_alarm = !emergency_stop_in || !forward_travel_limit_in
                               || !reverse_travel_limit_in;
    next_st.func.fwd_inhibit = !forward_travel_limit_in || !emergency_stop_in;
    next_st.func.rev_inhibit = !reverse_travel_limit_in || !emergency_stop_in;
    next_st.func.fwd_tlim = st.tlim_en && forward_torque_limit_sel;
    next_st.func.rev_tlim = st.tlim_en && reverse_torque_limit_sel;
    // Both jog inputs at once cancel each other
    next_st.func.jog_fwd = jog_forward_in && !jog_reverse_in
                           && forward_travel_limit_in && emergency_stop_in;
    next_st.func.jog_rev = jog_reverse_in && !jog_forward_in
                           && reverse_travel_limit_in && emergency_stop_in;
    next_st.func.pos_mode = torque_position_switch_in;
    // Gear select only counts in position mode
    if (torque_position_switch_in) begin
      next_st.func.gear_sel = {gear_numerator_sel_bit1, gear_numerator_sel_bit0};
    end else begin
      next_st.func.gear_sel = 2'h0;
    end
    next_st.gear_out = st.gear[next_st.func.gear_sel];

    // Address phase
    next_st.wr_pend = acc && hwrite;
    if (acc) begin
      next_st.wr_addr = ra;
    end
    if (acc && !hwrite) begin
      if (ra == sdi_pkg::OFS_CTRL) begin
        next_st.rdata = {31'h0, next_st.tlim_en};
      end else if (ra == sdi_pkg::OFS_DIN) begin
        next_st.rdata = {22'h0, din};
      end else if (ra == sdi_pkg::OFS_FUNC) begin
        next_st.rdata = {22'h0, st.func};
      end else if (ra == sdi_pkg::OFS_IRQ_STAT) begin
        next_st.rdata = {28'h0, irq_stat};
      end else if (ra == sdi_pkg::OFS_IRQ_EN) begin
        next_st.rdata = {28'h0, next_st.irq_en};
      end else if (ra >= sdi_pkg::OFS_GEAR0 && ra <= sdi_pkg::OFS_GEAR3
                   && ra[1:0] == 2'h0) begin
        next_st.rdata = {16'h0, next_st.gear[ra[3:2]]};
      end else begin
        next_st.rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.tlim_en <= 1'b0;
      st.irq_en <= sdi_pkg::IRQ_EN_RST;
      st.gear <= {sdi_pkg::N_GEAR{sdi_pkg::GEAR_RST}};
      st.prev_estop <= 1'b0;
      st.prev_fwd <= 1'b0;
      st.prev_rev <= 1'b0;
      st.prev_mode <= 1'b0;
      st.func <= '0;
      st.gear_out <= sdi_pkg::GEAR_RST;
      st.wr_pend <= 1'b0;
      st.wr_addr <= 8'h00;
      st.rdata <= 32'h0;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign fault_alarm_out = st.func.fault_alarm;
  assign fwd_motion_inhibit = st.func.fwd_inhibit;
  assign rev_motion_inhibit = st.func.rev_inhibit;
  assign fwd_torque_limit_on = st.func.fwd_tlim;
  assign rev_torque_limit_on = st.func.rev_tlim;
  assign jog_fwd_drive = st.func.jog_fwd;
  assign jog_rev_drive = st.func.jog_rev;
  assign position_mode = st.func.pos_mode;
  assign gear_sel = st.func.gear_sel;
  assign gear_numerator = st.gear_out;
  assign irq = |(irq_stat & st.irq_en);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_fwd_open;
    $fell(forward_travel_limit_in) ##1 !forward_travel_limit_in;
  endsequence

  sequence s_jog_fwd_ok;
    jog_forward_in && !jog_reverse_in && forward_travel_limit_in && emergency_stop_in;
  endsequence

  sequence s_jog_rev_ok;
    jog_reverse_in && !jog_forward_in && reverse_travel_limit_in && emergency_stop_in;
  endsequence

  a_estop_alarm: assert property (!emergency_stop_in |=> fault_alarm_out && fwd_motion_inhibit
    && rev_motion_inhibit) else $error("estop open without alarm");
  a_rev_limit_alarm: assert property (!reverse_travel_limit_in |=> fault_alarm_out
    && rev_motion_inhibit && !jog_rev_drive) else $error("reverse limit open without alarm");
  a_fwd_limit_alarm: assert property (!forward_travel_limit_in |=> fault_alarm_out
    && fwd_motion_inhibit && !jog_fwd_drive) else $error("forward limit open without alarm");
  a_rev_tlim_gate: assert property (rev_torque_limit_on == $past(st.tlim_en
    && reverse_torque_limit_sel)) else $error("reverse torque limit gating wrong");
  a_fwd_tlim_gate: assert property (forward_torque_limit_sel && !st.tlim_en |=>
    !fwd_torque_limit_on) else $error("forward torque limit not ignored");
  a_jog_fwd_drive: assert property (s_jog_fwd_ok |=> jog_fwd_drive && !jog_rev_drive)
    else $error("forward jog not driven");
  a_jog_rev_drive: assert property (s_jog_rev_ok |=> jog_rev_drive && !jog_fwd_drive)
    else $error("reverse jog not driven");
  a_gear_select: assert property (torque_position_switch_in |=> gear_sel ==
    {$past(gear_numerator_sel_bit1), $past(gear_numerator_sel_bit0)})
    else $error("gear select wrong in position mode");
  a_torque_gear: assert property (!torque_position_switch_in |=> !position_mode
    && gear_sel == 2'h0) else $error("torque mode decode wrong");
  a_limit_hold: assert property (s_fwd_open |=> fault_alarm_out && fwd_motion_inhibit)
    else $error("alarm dropped while forward limit open");
  a_limit_event: assert property ($fell(forward_travel_limit_in)
    |=> irq_stat[sdi_pkg::EV_FWD_LIM]) else $error("forward limit event not latched");
endmodule : sdi_top
`default_nettype wire

/* testbench/sdi_field.sv */
`default_nettype none
module sdi_field (
  // Contact pattern from the bench
  input wire logic [9:0] pat,
  // Field contacts and commands
  output logic estop,
  output logic fwd_lim,
  output logic rev_lim,
  output logic fwd_tsel,
  output logic rev_tsel,
  output logic jog_f,
  output logic jog_r,
  output logic gear0,
  output logic gear1,
  output logic tp_sw
);
  timeunit 1ns;
  timeprecision 1ns;
  // Closed contacts drive high
  assign {tp_sw, gear1, gear0, jog_r, jog_f, rev_tsel, fwd_tsel, rev_lim, fwd_lim, estop} = pat;
endmodule : sdi_field
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq, mon = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [9:0] pat = 10'h007, pv, pp = 10'h007;
  logic es, fl, rl, ft, rt, jf, jr, g0, g1, tp;
  logic fault_alarm_out, fwd_motion_inhibit, rev_motion_inhibit, fwd_torque_limit_on;
  logic rev_torque_limit_on, jog_fwd_drive, jog_rev_drive, position_mode;
  logic [1:0] gear_sel;
  logic [15:0] gear_numerator;
  int err_count = 0, checks_done = 0, m_stat = 0, m_tlim = 0, m_en = 0;
  int gm[4] = '{1, 1, 1, 1};
  always #20 hclk = ~hclk;
  sdi_field i_field (.pat(pat), .estop(es), .fwd_lim(fl), .rev_lim(rl), .fwd_tsel(ft),
    .rev_tsel(rt), .jog_f(jf), .jog_r(jr), .gear0(g0), .gear1(g1), .tp_sw(tp));
  sdi_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .emergency_stop_in(es),
    .forward_travel_limit_in(fl), .reverse_travel_limit_in(rl), .forward_torque_limit_sel(ft),
    .reverse_torque_limit_sel(rt), .jog_forward_in(jf), .jog_reverse_in(jr),
    .gear_numerator_sel_bit0(g0), .gear_numerator_sel_bit1(g1), .torque_position_switch_in(tp),
    .fault_alarm_out, .fwd_motion_inhibit, .rev_motion_inhibit, .fwd_torque_limit_on,
    .rev_torque_limit_on, .jog_fwd_drive, .jog_rev_drive, .position_mode, .gear_sel,
    .gear_numerator, .irq);
  function automatic logic [9:0] fexp(input logic [9:0] v, input int tl);
    return {!v[0] | !v[1] | !v[2], !v[1] | !v[0], !v[2] | !v[0], v[3] & tl[0], v[4] & tl[0],
      v[5] & !v[6] & v[1] & v[0], v[6] & !v[5] & v[2] & v[0], v[9], v[9] ? v[8:7] : 2'b00};
  endfunction : fexp
  task automatic results;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_count++;
      results;
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask : bus
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, q, x);
  endtask : rdc
  // Reference model follows every sampled contact pattern
  always @(posedge hclk) if (hresetn) begin
    logic [9:0] e;
    pv = pat;
    m_stat |= {pp[9] ^ pv[9], pp[2] & !pv[2], pp[1] & !pv[1], pp[0] & !pv[0]};
    pp = pv;
    if (mon) begin
      #1;
      e = fexp(pv, m_tlim);
      chk("alarm", fault_alarm_out, e[9]);
      chk("inhibit", {fwd_motion_inhibit, rev_motion_inhibit}, e[8:7]);
      chk("tlim", {fwd_torque_limit_on, rev_torque_limit_on}, e[6:5]);
      chk("jog", {jog_fwd_drive, jog_rev_drive}, e[4:3]);
      chk("mode", position_mode, e[2]);
      chk("gear", {gear_sel, gear_numerator}, {e[1:0], 16'(gm[e[1:0]])});
    end
  end
  initial begin
    logic [31:0] q;
    logic [31:0] wv;
    logic [9:0] v;
    logic [7:0] ga;
    void'($urandom(42689));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ctrl", sdi_pkg::OFS_CTRL, 32'h0);
    rdc("irq_en", sdi_pkg::OFS_IRQ_EN, 32'h0);
    rdc("unmapped", 8'h3c, 32'h0);
    for (int i = 0; i < 4; i++) begin
      ga = sdi_pkg::OFS_GEAR0 + 8'(4 * i);
      rdc("gear_rst", ga, 32'h1);
      wv = $urandom;
      bus(1'b1, ga, wv, q);
      gm[i] = wv & 32'hffff;
      rdc("gear_rw", ga, gm[i]);
    end
    bus(1'b1, sdi_pkg::OFS_DIN, 32'hffff, q);
    rdc("din", sdi_pkg::OFS_DIN, 32'(pat));
    bus(1'b1, sdi_pkg::OFS_IRQ_CLR, 32'hf, q);
    m_stat = 0;
    for (int ph = 0; ph < 2; ph++) begin
      m_tlim = ph;
      m_en = $urandom % 16;
      bus(1'b1, sdi_pkg::OFS_CTRL, ph, q);
      bus(1'b1, sdi_pkg::OFS_IRQ_EN, m_en, q);
      mon <= 1'b1;
      repeat (400) begin
        @(posedge hclk);
        v = $urandom;
        if ($urandom % 4 != 0) v[2:0] = 3'b111;
        pat <= v;
      end
      repeat (3) @(posedge hclk);
      mon <= 1'b0;
      rdc("func", sdi_pkg::OFS_FUNC, 32'(fexp(pat, m_tlim)));
      rdc("stat", sdi_pkg::OFS_IRQ_STAT, m_stat);
      chk("irq", irq, (m_stat & m_en) != 0);
      bus(1'b1, sdi_pkg::OFS_IRQ_CLR, 32'hf, q);
      m_stat = 0;
      rdc("stat_clr", sdi_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq_clr", irq, 1'b0);
    end
    results;
  end
endmodule : tb_top
`default_nettype wire
